// [include/hicr_pkg.sv]
// Package for the hub identity and first configuration byte register bank.
// Assumes a single hub clock domain and a byte-wide register write/read port.
package hicr_pkg;

  localparam logic [7:0] HICR_OFF_PRODUCT_ID_HIGH     = 8'h03;
  localparam logic [7:0] HICR_OFF_RELEASE_NUMBER_LOW  = 8'h04;
  localparam logic [7:0] HICR_OFF_RELEASE_NUMBER_HIGH = 8'h05;
  localparam logic [7:0] HICR_OFF_HUB_CONFIG_FIRST    = 8'h06;

  localparam logic [7:0] HICR_RST_BYTE = 8'h00;

  localparam int HICR_BIT_POWER_SOURCE = 7;
  localparam int HICR_BIT_RESERVED     = 6;
  localparam int HICR_BIT_FULL_SPEED   = 5;

  // Writable bits of the first configuration byte; bit 6 is reserved
  localparam logic [7:0] HICR_CFG_WRITE_MASK = 8'hBF;

  typedef enum logic [2:0] {
    HICR_ACC_IDLE  = 3'h1,
    HICR_ACC_WRITE = 3'h2,
    HICR_ACC_READ  = 3'h4
  } hicr_acc_t;

endpackage

// [hdl/hicr_sync.sv]
// Two-flop synchroniser for a single level coming in from a pin.
// Assumes the destination clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module hicr_sync
  import hicr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } hicr_sync_state_t;

  hicr_sync_state_t state_reg;
  hicr_sync_state_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = d_i;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_o = state_reg.sync;

endmodule // hicr_sync

// [hdl/hicr_regs.sv]
// Hub identity and first configuration byte register bank.
// Assumes SMBus or EEPROM loader logic on MCLK_I presents byte accesses.
//
// What this block does
// - Hold product identifier upper byte, report upstream.
// - Release number BCD, low/high bytes, reported unchanged.
// - Config bit 7: clear bus-, set self-powered.
// - Dynamic switching: local sense pin picks power.
// - Config bit 5 set forces full-speed-only attach.
//
// Register map, one byte each, all reset to zero:
//   0x03 product identifier upper byte
//   0x04 release number low byte
//   0x05 release number high byte
//   0x06 first configuration byte: bit 7 power source, bit 6 reserved,
//        bit 5 full-speed only, bits 4:0 stored only
`timescale 1ns/1ps
module hicr_regs
  import hicr_pkg::*;
(
  input  wire logic       MCLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       DYN_POWER_SWITCH_EN_I,
  input  wire logic       LOCAL_SUPPLY_SENSE_PIN_I,
  output logic      [7:0] REG_RDATA_O,
  output logic            REG_RVALID_O,
  output logic            REG_HIT_O,
  output logic      [7:0] PRODUCT_ID_HIGH_O,
  output logic     [15:0] RELEASE_NUMBER_O,
  output logic            SELF_POWERED_O,
  output logic            FULL_SPEED_ONLY_O
);

  typedef struct packed {
    // Stored registers
    logic [7:0]  product_id_high;
    logic [7:0]  release_number_low;
    logic [7:0]  release_number_high;
    logic [7:0]  hub_config_first;
    // Dynamic switching enable, registered once
    logic        dyn_en;
    // Register port answer and derived outputs
    logic [7:0]  rdata;
    logic        rvalid;
    logic        hit;
    logic        self_powered;
    logic        full_speed_only;
    hicr_acc_t   acc;
  } hicr_state_t;

  hicr_state_t state_reg;
  hicr_state_t state_next;
  logic        sense_sync;

  // Address decode shared by the write and read paths
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      HICR_OFF_PRODUCT_ID_HIGH: begin
        addr_mapped = 1'b1;
      end
      HICR_OFF_RELEASE_NUMBER_LOW: begin
        addr_mapped = 1'b1;
      end
      HICR_OFF_RELEASE_NUMBER_HIGH: begin
        addr_mapped = 1'b1;
      end
      HICR_OFF_HUB_CONFIG_FIRST: begin
        addr_mapped = 1'b1;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  endfunction

  // Reserved bit of the first configuration byte is never stored
  function automatic logic [7:0] cfg_filter(input logic [7:0] w);
    cfg_filter                    = w & HICR_CFG_WRITE_MASK;
    cfg_filter[HICR_BIT_RESERVED] = 1'b0;
  endfunction

  // Read value of one byte register; unmapped addresses read as zero
  function automatic logic [7:0] read_select(input logic [7:0]  a,
                                             input hicr_state_t s);
    case (a)
      HICR_OFF_PRODUCT_ID_HIGH: begin
        read_select = s.product_id_high;
      end
      HICR_OFF_RELEASE_NUMBER_LOW: begin
        read_select = s.release_number_low;
      end
      HICR_OFF_RELEASE_NUMBER_HIGH: begin
        read_select = s.release_number_high;
      end
      HICR_OFF_HUB_CONFIG_FIRST: begin
        read_select = cfg_filter(s.hub_config_first);
      end
      default: begin
        read_select = HICR_RST_BYTE;
      end
    endcase
  endfunction

  // Self-powered decision: sense pin under dynamic switching, stored bit otherwise
  function automatic logic power_select(input logic       dyn,
                                        input logic       sense,
                                        input logic [7:0] cfg);
    if (dyn) begin
      power_select = sense;
    end else begin
      power_select = cfg[HICR_BIT_POWER_SOURCE];
    end
  endfunction

  // Full-speed-only attach is the stored bit, with no pin override
  function automatic logic speed_select(input logic [7:0] cfg);
    speed_select = cfg[HICR_BIT_FULL_SPEED];
  endfunction

  hicr_sync u_sense_sync (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .d_i      (LOCAL_SUPPLY_SENSE_PIN_I),
    .q_o      (sense_sync)
  );

  // Next state of the whole block
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    state_next.dyn_en = DYN_POWER_SWITCH_EN_I;

    // Write wins when both strobes are high
    if (REG_WR_I) begin
      state_next.acc = HICR_ACC_WRITE;
    end else if (REG_RD_I) begin
      state_next.acc = HICR_ACC_READ;
    end else begin
      state_next.acc = HICR_ACC_IDLE;
    end

    // Strobe and hit flag follow the kind of access taken this cycle
    case (state_next.acc)
      HICR_ACC_WRITE: begin
        state_next.hit = addr_mapped(REG_ADDR_I);
      end
      HICR_ACC_READ: begin
        state_next.rvalid = 1'b1;
        state_next.hit    = addr_mapped(REG_ADDR_I);
        state_next.rdata  = read_select(REG_ADDR_I, state_reg);
      end
      HICR_ACC_IDLE: begin
        state_next.hit = state_reg.hit;
      end
      default: begin
        state_next.hit = state_reg.hit;
      end
    endcase

    // Writes arrive from the SMBus slave or the EEPROM loader
    if (state_next.acc == HICR_ACC_WRITE) begin
      case (REG_ADDR_I)
        HICR_OFF_PRODUCT_ID_HIGH: begin
          state_next.product_id_high = REG_WDATA_I;
        end
        HICR_OFF_RELEASE_NUMBER_LOW: begin
          state_next.release_number_low = REG_WDATA_I;
        end
        HICR_OFF_RELEASE_NUMBER_HIGH: begin
          state_next.release_number_high = REG_WDATA_I;
        end
        HICR_OFF_HUB_CONFIG_FIRST: begin
          state_next.hub_config_first = cfg_filter(REG_WDATA_I);
        end
        default: begin
          // Unmapped writes are dropped; the hit flag reports them
        end
      endcase
    end

    // Derived outputs lag the stored byte, or the synchronised sense pin, by one cycle
    state_next.self_powered    = power_select(state_reg.dyn_en, sense_sync,
                                              state_reg.hub_config_first);
    state_next.full_speed_only = speed_select(state_reg.hub_config_first);
  end

  // Asynchronous reset clears every field to a constant
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg                     <= '0;
      state_reg.product_id_high     <= HICR_RST_BYTE;
      state_reg.release_number_low  <= HICR_RST_BYTE;
      state_reg.release_number_high <= HICR_RST_BYTE;
      state_reg.hub_config_first    <= HICR_RST_BYTE;
      state_reg.dyn_en              <= 1'b0;
      state_reg.rdata               <= HICR_RST_BYTE;
      state_reg.rvalid              <= 1'b0;
      state_reg.hit                 <= 1'b0;
      state_reg.self_powered        <= 1'b0;
      state_reg.full_speed_only     <= 1'b0;
      state_reg.acc                 <= HICR_ACC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output comes straight from a register
  assign REG_RDATA_O       = state_reg.rdata;
  assign REG_RVALID_O      = state_reg.rvalid;
  assign REG_HIT_O         = state_reg.hit;
  assign PRODUCT_ID_HIGH_O = state_reg.product_id_high;
  assign RELEASE_NUMBER_O  = {state_reg.release_number_high,
                              state_reg.release_number_low};
  assign SELF_POWERED_O    = state_reg.self_powered;
  assign FULL_SPEED_ONLY_O = state_reg.full_speed_only;

endmodule // hicr_regs

// [dv/hicr_regs_sva.sv]
// Checker for the identity and first configuration byte bank.
// Sees only the top module ports; bound below.
`timescale 1ns/1ps
module hicr_regs_sva (
  input wire logic        MCLK_I,
  input wire logic        ARST_N_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        DYN_POWER_SWITCH_EN_I,
  input wire logic        LOCAL_SUPPLY_SENSE_PIN_I,
  input wire logic [7:0]  REG_RDATA_O,
  input wire logic [7:0]  PRODUCT_ID_HIGH_O,
  input wire logic [15:0] RELEASE_NUMBER_O,
  input wire logic        SELF_POWERED_O,
  input wire logic        FULL_SPEED_ONLY_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  wire       w = REG_WR_I;
  wire [7:0] a = REG_ADDR_I;
  wire [7:0] d = REG_WDATA_I;
  AST_PID: assert property (
    w && a == 8'h03 |=> PRODUCT_ID_HIGH_O == $past(d)) else $error("id high wrong");
  AST_REL: assert property (
    w && a == 8'h05 |=> RELEASE_NUMBER_O[15:8] == $past(d)) else $error("release wrong");
  AST_PWR: assert property (
    !DYN_POWER_SWITCH_EN_I && w && a == 8'h06 |=> ##1 SELF_POWERED_O == $past(d[7], 2))
    else $error("power mode wrong");
  AST_DYN: assert property (
    DYN_POWER_SWITCH_EN_I [*4] |-> SELF_POWERED_O == $past(LOCAL_SUPPLY_SENSE_PIN_I, 3))
    else $error("sense pin ignored");
  AST_FSO: assert property (
    w && a == 8'h06 |=> ##1 FULL_SPEED_ONLY_O == $past(d[5], 2)) else $error("speed wrong");
  AST_RSV: assert property (
    REG_RD_I && !w && a == 8'h06 |=> !REG_RDATA_O[6]) else $error("reserved bit set");
  cover property (DYN_POWER_SWITCH_EN_I && SELF_POWERED_O);
  cover property (FULL_SPEED_ONLY_O);
  cover property (REG_RD_I && a == 8'h04);
endmodule // hicr_regs_sva
bind hicr_regs hicr_regs_sva i_hicr_regs_sva (.*);

// [dv/hicr_cfg_host.sv]
// Configuring party model: byte writes and reads on the register port.
// Assumes the fixed one-cycle read answer of the bank.
`timescale 1ns/1ps
module hicr_cfg_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
  // Data lines are scrambled once released
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'h1; addr_o <= a; wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'h0; wdata_o <= ~d;
  endtask
  task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'h1; addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'h0;
    #1 d = rvalid_i ? rdata_i : 8'hXX;
  endtask
endmodule // hicr_cfg_host

// [dv/hicr_regs_tb_top.sv]
// Testbench for the identity and first configuration byte bank.
// Drives the register port through the host model.
`timescale 1ns/1ps
module hicr_regs_tb_top;
  logic        mclk = 1'h0, arst_n = 1'h0, dyn = 1'h0, pin = 1'h0;
  logic        wr, rd, rvalid, sp, fso, hit;
  logic [7:0]  addr, wdata, rdata, pid, d;
  logic [15:0] rel;
  int          failures = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  hicr_cfg_host i_hicr_cfg_host (.clk_i(mclk), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr),
    .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  hicr_regs i_hicr_regs (.MCLK_I(mclk), .ARST_N_I(arst_n), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .DYN_POWER_SWITCH_EN_I(dyn),
    .LOCAL_SUPPLY_SENSE_PIN_I(pin), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REG_HIT_O(hit),
    .PRODUCT_ID_HIGH_O(pid), .RELEASE_NUMBER_O(rel), .SELF_POWERED_O(sp),
    .FULL_SPEED_ONLY_O(fso));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_ident;
    i_hicr_cfg_host.wr_b(8'h03, 8'hA5);
    i_hicr_cfg_host.wr_b(8'h04, 8'h34);
    i_hicr_cfg_host.wr_b(8'h05, 8'h12);
    i_hicr_cfg_host.rd_b(8'h04, d);
    chk(d, 8'h34);
    chk(hit, 1'h1);
    chk(pid, 8'hA5);
    chk(rel, 16'h1234);
    i_hicr_cfg_host.rd_b(8'h07, d);
    chk(d, 8'h00);
    chk(hit, 1'h0);
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 4; i++) begin
      i_hicr_cfg_host.wr_b(8'h06, {i[1], 1'h1, i[0], 5'h1F});
      i_hicr_cfg_host.rd_b(8'h06, d);
      chk(d, {i[1], 1'h0, i[0], 5'h1F});
      chk(sp, i[1]);
      chk(fso, i[0]);
    end
  endtask
  task automatic t_dyn;
    @(posedge mclk) dyn <= 1'h1;
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk) pin <= j[0];
      repeat (4) @(posedge mclk);
      #1 chk(sp, j[0]);
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'h1;
    t_ident;
    t_cfg;
    t_dyn;
    end_sim;
  end
  initial begin
    #100000;
    failures++;
    end_sim;
  end
endmodule // hicr_regs_tb_top
